// ---- design/swr_top.sv ----
// Sleep entry, wake-up and reset-cause control with an APB register port
// Functional notes
// - Sleep command enters power-down state
// - Sleep clears enabled watchdog, keeps running
// - Sleep sets active-low time-out flag bit 4
// - Sleep clears active-low power-down flag bit 3
// - Sleep stops main oscillator driver
// - Pins hold drive state during sleep
// - Watchdog reset never pulls master-clear pin
// - Master-clear wakes only when pin enabled
// - Enabled watchdog time-out wakes from sleep
// - Every wake-up is a full reset
// - Watchdog time-out clears time-out flag
// - Power-up sets power-down flag
// - Pin change in sleep sets wake flag
// - Compare pins against last pins register read
// - Watchdog cleared on every wake-up
// - Watchdog wake starts device reset timer
// - Cause flags encode reset source
// - Flags hold; master-clear pulse clears only the wake flag
`timescale 1ns/100ps
module swr_top
  import swr_pkg::*;
#(
  parameter int unsigned DRT_LONG = DRT_LONG_CYC,
  parameter int unsigned DRT_SHORT = DRT_SHORT_CYC,
  parameter int unsigned WDT_PERIOD = WDT_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Pins
  input wire logic master_clear_pin_n_i,
  input wire logic [NPIN-1:0] pin_in_i,
  output logic [NPIN-1:0] pin_out_o,
  output logic [NPIN-1:0] pin_oe_o,
  // Core control
  output logic osc_enable_o,
  output logic core_reset_o
);

  swr_state_t state;
  logic [31:0] ctrl;
  swr_cause_t cause;
  swr_port_t port;
  logic [NPIN-1:0] pin_latch;
  logic [NPIN-1:0] s1, s2, s3, pins;
  logic [2:0] master_clear_pin_sync;
  logic master_clear_pin_low;
  logic [CNT_W-1:0] wdt_cnt;
  logic [CNT_W-1:0] drt_cnt;
  logic wdt_timeout;
  logic wake_change;
  logic [NWAKE-1:0] wake_mask;

  // APB decode
  logic acc, wr, rd;
  assign acc = psel_i & penable_i & pready_o;
  assign wr = acc & pwrite_i;
  assign rd = acc & ~pwrite_i;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic mapped;
  assign mapped = hit(paddr_i, ADDR_CTRL) | hit(paddr_i, ADDR_STATUS) |
                  hit(paddr_i, ADDR_PINS) | hit(paddr_i, ADDR_PORT);

  logic sleep_cmd, clrwdt_cmd;
  assign sleep_cmd = wr & hit(paddr_i, ADDR_CTRL) & pwdata_i[CTRL_SLEEP] &
                     (state == SWR_RUN);
  assign clrwdt_cmd = wr & hit(paddr_i, ADDR_CTRL) & pwdata_i[CTRL_CLRWDT];

  // Three-stage pin synchronisers; change accepted when stages 2 and 3 agree
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      master_clear_pin_sync <= 3'h7;
    end else begin
      s1 <= pin_in_i;
      s2 <= s1;
      s3 <= s2;
      master_clear_pin_sync <= {master_clear_pin_sync[1:0], master_clear_pin_n_i};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_filt
      always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          pins[g] <= 1'b0;
        end else if (s2[g] == s3[g]) begin
          pins[g] <= s3[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      master_clear_pin_low <= 1'b0;
    end else if (master_clear_pin_sync[1] == master_clear_pin_sync[2]) begin
      master_clear_pin_low <= ~master_clear_pin_sync[2];
    end
  end

  // Wake inputs 0, 1, 3 and optionally 4
  assign wake_mask = {ctrl[CTRL_PB4], 3'b111};
  logic [NWAKE-1:0] mon_now, mon_old;
  assign mon_now = {pins[4], pins[3], pins[1], pins[0]};
  assign mon_old = {pin_latch[4], pin_latch[3], pin_latch[1], pin_latch[0]};
  assign wake_change = ctrl[CTRL_WAKE_EN] & |((mon_now ^ mon_old) & wake_mask);

  assign wdt_timeout = ctrl[CTRL_WDT_EN] && (wdt_cnt >= CNT_W'(WDT_PERIOD - 1));

  logic master_clear_pin_wake;
  assign master_clear_pin_wake = ctrl[CTRL_MASTER_CLEAR_PIN_EN] & master_clear_pin_low;

  // Control register; configuration survives wake resets
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= CTRL_RESET;
    end else if (wr && hit(paddr_i, ADDR_CTRL)) begin
      ctrl <= {23'h000000, 1'b0, 3'h0, pwdata_i[CTRL_PB4:0]};
    end
  end

  // Port drive and latch of last pins register read
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      port <= '0;
      pin_latch <= '0;
    end else begin
      if (wr && hit(paddr_i, ADDR_PORT) && state == SWR_RUN) begin
        port <= pwdata_i[2*NPIN-1:0];
      end
      if (rd && hit(paddr_i, ADDR_PINS)) begin
        pin_latch <= pins;
      end
    end
  end

  // Sleep / reset sequencer
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= SWR_RESET;
      drt_cnt <= '0;
    end else begin
      unique case (state)
        SWR_RUN: begin
          if (sleep_cmd) begin
            state <= SWR_SLEEP;
          end else if (wdt_timeout) begin
            state <= SWR_RESET;
            drt_cnt <= CNT_W'(ctrl[CTRL_XTAL] ? DRT_LONG : DRT_SHORT);
          end else if (master_clear_pin_wake) begin
            // Master clear while running holds the core; time-out and power-down flags keep their values, wake flag clears
            state <= SWR_RESET;
            drt_cnt <= CNT_W'(ctrl[CTRL_XTAL] ? DRT_LONG : DRT_SHORT);
          end
        end
        SWR_SLEEP: begin
          if (master_clear_pin_wake || wdt_timeout || wake_change) begin
            state <= SWR_RESET;
            drt_cnt <= CNT_W'(ctrl[CTRL_XTAL] ? DRT_LONG : DRT_SHORT);
          end
        end
        SWR_RESET: begin
          if (master_clear_pin_wake) begin
            drt_cnt <= CNT_W'(ctrl[CTRL_XTAL] ? DRT_LONG : DRT_SHORT);
          end else if (drt_cnt > CNT_W'(1)) begin
            drt_cnt <= drt_cnt - CNT_W'(1);
          end else begin
            state <= SWR_RUN;
            drt_cnt <= '0;
          end
        end
        default: state <= SWR_RESET;
      endcase
    end
  end

  // Watchdog counter
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt_cnt <= '0;
    end else if (sleep_cmd || clrwdt_cmd || state == SWR_RESET || wdt_timeout) begin
      wdt_cnt <= '0;
    end else if (ctrl[CTRL_WDT_EN]) begin
      wdt_cnt <= wdt_cnt + CNT_W'(1);
    end
  end

  // Reset-cause flags; reset events and the sleep and watchdog-clear commands change them
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cause <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1,
                 pin_change_wake_flag: 1'b0};
    end else if (state == SWR_RUN && sleep_cmd) begin
      cause.timeout_flag_n <= 1'b1;
      cause.powerdown_flag_n <= 1'b0;
    end else if (state == SWR_RUN && clrwdt_cmd) begin
      cause.timeout_flag_n <= 1'b1;
      cause.powerdown_flag_n <= 1'b1;
    end else if (state == SWR_RUN && wdt_timeout) begin
      cause.timeout_flag_n <= 1'b0;
      cause.pin_change_wake_flag <= 1'b0;
    end else if (state == SWR_SLEEP) begin
      // Priority: master clear, then watchdog, then pin change
      if (master_clear_pin_wake) begin
        cause.pin_change_wake_flag <= 1'b0;
      end else if (wdt_timeout) begin
        cause.timeout_flag_n <= 1'b0;
        cause.pin_change_wake_flag <= 1'b0;
      end else if (wake_change) begin
        cause.pin_change_wake_flag <= 1'b1;
      end
    end else if (state == SWR_RUN && master_clear_pin_wake) begin
      cause.pin_change_wake_flag <= 1'b0;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_enable_o <= 1'b1;
      core_reset_o <= 1'b1;
      pin_out_o <= '0;
      pin_oe_o <= '0;
      prdata_o <= '0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      osc_enable_o <= ~(state == SWR_SLEEP || sleep_cmd);
      // Watchdog reset stays internal; no drive on master-clear pin exists
      core_reset_o <= (state == SWR_RESET);
      pin_out_o <= port.out;
      pin_oe_o <= port.oe;
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      prdata_o <= '0;
      if (psel_i && !penable_i && !pwrite_i) begin
        if (hit(paddr_i, ADDR_CTRL)) begin
          prdata_o <= ctrl;
        end else if (hit(paddr_i, ADDR_STATUS)) begin
          prdata_o <= {22'h0, state == SWR_RESET, state == SWR_SLEEP,
                       cause.pin_change_wake_flag, 2'h0, cause.timeout_flag_n,
                       cause.powerdown_flag_n, 3'h0};
        end else if (hit(paddr_i, ADDR_PINS)) begin
          prdata_o <= {24'h0, pins};
        end else if (hit(paddr_i, ADDR_PORT)) begin
          prdata_o <= {16'h0, port};
        end
      end
    end
  end

endmodule

// ---- dv/sleep_wakeup_reset_control_tb.sv ----
// Directed bench for the sleep, wake-up and reset control block
`timescale 1ns/100ps
module sleep_wakeup_reset_control_tb;
  import swr_pkg::*;
  logic clk_sys_i = 1'b0, arst_n_i = 1'b0, press = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, level = 8'h00, pins, pin_out_o, pin_oe_o;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, er, osc_enable_o, core_reset_o, master_clear_pin_n;
  int fails = 0, check_count = 0, t;
  int wk[4] = '{0, 1, 3, 4};
  initial forever #4 clk_sys_i = ~clk_sys_i;
  swr_pins_model pm (.clk_sys_i, .press_i(press), .level_i(level), .master_clear_pin_n_o(master_clear_pin_n),
    .pin_o(pins));
  // Short timer counts keep the run brief
  swr_top #(.DRT_LONG(20), .DRT_SHORT(5), .WDT_PERIOD(100)) uut (.clk_sys_i, .arst_n_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .master_clear_pin_n_i(master_clear_pin_n), .pin_in_i(pins), .pin_out_o, .pin_oe_o, .osc_enable_o,
    .core_reset_o);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    t = 0;
    while (s !== v && t < lim) begin
      @(posedge clk_sys_i);
      t++;
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic st(input string nm, input logic [31:0] exp);
    wt(core_reset_o, 1'b0, 60);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(nm, rd, exp);
  endtask
  // Reading the pins first arms the change compare
  task automatic nap(input logic [31:0] c, input logic look);
    apb(1'b1, ADDR_CTRL, c);
    if (look) apb(1'b0, ADDR_PINS, 32'h0);
    apb(1'b1, ADDR_CTRL, c | 32'h100);
    wt(osc_enable_o, 1'b0, 8);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #40000;
    fails++;
    close_out();
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    st("por", 32'h18);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", er, 1'b1);
    $display("power-up test done");
    apb(1'b1, ADDR_PORT, 32'hf0a5);
    apb(1'b1, ADDR_CTRL, 32'h201);
    repeat (60) @(posedge clk_sys_i);
    nap(32'h9, 1'b1);
    apb(1'b1, ADDR_PORT, 32'h0);
    chk("pins", {pin_out_o, pin_oe_o}, 16'hf0a5);
    chk("osc", osc_enable_o, 1'b0);
    wt(osc_enable_o, 1'b1, 200);
    chk("wdt_span", t > 85, 1'b1);
    repeat (2) @(posedge clk_sys_i);
    wt(core_reset_o, 1'b0, 60);
    chk("drt", t inside {[16:24]}, 1'b1);
    st("wdt", 32'h0);
    $display("watchdog test done");
    nap(32'h4, 1'b1);
    press <= 1'b1;
    wt(osc_enable_o, 1'b1, 20);
    chk("master_clear_pin_wake", osc_enable_o, 1'b1);
    press <= 1'b0;
    st("master_clear_pin", 32'h10);
    nap(32'h2, 1'b1);
    press <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    chk("master_clear_pin_off", osc_enable_o, 1'b0);
    press <= 1'b0;
    level <= 8'h02;
    wt(osc_enable_o, 1'b1, 20);
    chk("pin_wake", osc_enable_o, 1'b1);
    st("pcw", 32'h90);
    nap(32'h2, 1'b0);
    repeat (30) @(posedge clk_sys_i);
    st("stale", 32'h90);
    foreach (wk[i]) begin
      nap(32'h12, 1'b1);
      level <= level ^ 8'h24;
      repeat (12) @(posedge clk_sys_i);
      chk("other_pins", osc_enable_o, 1'b0);
      level <= level ^ (8'h01 << wk[i]);
      wt(osc_enable_o, 1'b1, 20);
      chk("wake_in", osc_enable_o, 1'b1);
      st("pcw_in", 32'h90);
    end
    $display("wake test done");
    apb(1'b1, ADDR_CTRL, 32'h5);
    press <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
    press <= 1'b0;
    st("master_clear_pin_run", 32'h10);
    repeat (120) @(posedge clk_sys_i);
    st("wdt_run", 32'h0);
    $display("flag test done");
    close_out();
  end
endmodule

// ---- dv/swr_pins_model.sv ----
// Far side model: master-clear switch and wake input pins
`timescale 1ns/100ps
module swr_pins_model
  import swr_pkg::*;
(
  // Bench side
  input wire logic clk_sys_i,
  input wire logic press_i,
  input wire logic [NPIN-1:0] level_i,
  // Device pins
  output logic master_clear_pin_n_o,
  output logic [NPIN-1:0] pin_o
);
  // Pulled-up switch, so idle reads high
  logic master_clear_pin_q = 1'b1;
  logic [NPIN-1:0] pin_q = '0;
  always @(posedge clk_sys_i) begin
    master_clear_pin_q <= !press_i;
    pin_q <= level_i;
  end
  assign master_clear_pin_n_o = master_clear_pin_q;
  assign pin_o = pin_q;
endmodule

// ---- dv/swr_properties.sv ----
// Port checker for the sleep and wake-up control block
`timescale 1ns/100ps
module swr_properties
  import swr_pkg::*;
(
  // Clock, reset and APB
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pins and core
  input wire logic [NPIN-1:0] pin_out_o,
  input wire logic [NPIN-1:0] pin_oe_o,
  input wire logic osc_enable_o,
  input wire logic core_reset_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence s_asleep;
    !osc_enable_o [*2];
  endsequence
  a_pins_frozen: assert property (s_asleep |-> $stable({pin_oe_o, pin_out_o}))
    else $error("pins moved in sleep");
  a_wake_resets: assert property ($rose(osc_enable_o) |-> ##[0:2] core_reset_o)
    else $error("wake without reset");
  a_sleep_no_reset: assert property (!osc_enable_o |-> !core_reset_o)
    else $error("reset while asleep");
  a_reset_osc_on: assert property (core_reset_o |-> osc_enable_o)
    else $error("osc off in reset");
  a_reset_min: assert property ($rose(core_reset_o) |-> core_reset_o [*4])
    else $error("reset too short");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready held");
  a_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready");
  a_err_unmapped: assert property (pready_o && paddr_i > ADDR_PORT |-> pslverr_o)
    else $error("no error");
endmodule
bind swr_top swr_properties u_props (.clk_sys_i, .arst_n_i, .psel_i, .penable_i, .paddr_i,
  .pready_o, .pslverr_o, .pin_out_o, .pin_oe_o, .osc_enable_o, .core_reset_o);

// ---- shared/swr_pkg.sv ----
// Package for the sleep, wake-up and reset control block
package swr_pkg;

  // Clock, device reset timer and watchdog figures
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned DRT_LONG_MS = 18;
  localparam int unsigned DRT_SHORT_US = 10;
  localparam int unsigned DRT_LONG_CYC = DRT_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned DRT_SHORT_CYC = DRT_SHORT_US * CLK_MHZ;
  localparam int unsigned WDT_PERIOD_MS = 18;
  localparam int unsigned WDT_PERIOD_CYC = WDT_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 32;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PINS = 8'h08;
  localparam logic [7:0] ADDR_PORT = 8'h0c;

  // Control register fields
  localparam int unsigned CTRL_WDT_EN = 0;
  localparam int unsigned CTRL_WAKE_EN = 1;
  localparam int unsigned CTRL_MASTER_CLEAR_PIN_EN = 2;
  localparam int unsigned CTRL_XTAL = 3;
  localparam int unsigned CTRL_PB4 = 4;
  localparam int unsigned CTRL_SLEEP = 8;
  localparam int unsigned CTRL_CLRWDT = 9;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0007;

  // Status register fields
  localparam int unsigned ST_PD_N = 3;
  localparam int unsigned ST_TO_N = 4;
  localparam int unsigned ST_PCW = 7;
  localparam int unsigned ST_SLEEPING = 8;
  localparam int unsigned ST_IN_RESET = 9;

  localparam int unsigned NPIN = 8;
  localparam int unsigned NWAKE = 4;

  typedef enum logic [2:0] {
    SWR_RUN = 3'b001,
    SWR_SLEEP = 3'b010,
    SWR_RESET = 3'b100
  } swr_state_t;

  typedef struct packed {
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic pin_change_wake_flag;
  } swr_cause_t;

  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
  } swr_port_t;

endpackage
